// ===== rtl/obdcp_pkg.sv
// Purpose: constants for the serial command interpreter
// Assumes: 100 MHz clock
// Notes:   register offsets are byte addresses of 32-bit words
package obdcp_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam longint CLK_HZ        = 100000000;
  localparam longint LINE_TMO_S    = 20;
  localparam logic [31:0] LINE_TMO_CYC = 32'(LINE_TMO_S * CLK_HZ);
  localparam logic [9:0]  RESP_STEP_MS = 10'h004;
  localparam logic [12:0] WAKE_STEP_MS = 13'h0014;
  // ****************************************
  // line buffer and characters
  // ****************************************
  localparam int BUF_N = 32;
  localparam logic [7:0] CH_CR  = 8'h0d;
  localparam logic [7:0] CH_SP  = 8'h20;
  localparam logic [7:0] CH_DEL = 8'h7f;
  localparam logic [47:0] MSG_ERR    = 48'h0000_003e_0d3f;
  localparam logic [47:0] MSG_OK     = 48'h0000_3e0d_4b4f;
  localparam logic [47:0] MSG_PROMPT = 48'h0000_0000_003e;
  // ****************************************
  // setting flags
  // ****************************************
  localparam int FLG_ECHO = 0;
  localparam int FLG_HDR  = 1;
  localparam int FLG_SPC  = 2;
  localparam int FLG_RSP  = 3;
  localparam int FLG_DLC  = 4;
  localparam int FLG_VDLC = 5;
  localparam int FLG_KW   = 6;
  localparam int FLG_CAF  = 7;
  localparam int FLG_CFC  = 8;
  localparam int FLG_CSM  = 9;
  localparam logic [9:0] FLAGS_RST = 10'h3cd;
  localparam logic [7:0] RESP_RST  = 8'h32;
  localparam logic [7:0] WAKE_RST  = 8'h92;
  // ****************************************
  // keyword rates and protocol ranges
  // ****************************************
  localparam logic [1:0]  KB_10400 = 2'h0;
  localparam logic [1:0]  KB_4800  = 2'h1;
  localparam logic [1:0]  KB_9600  = 2'h2;
  localparam logic [16:0] BAUD_10400 = 17'h028a0;
  localparam logic [16:0] BAUD_4800  = 17'h012c0;
  localparam logic [16:0] BAUD_9600  = 17'h02580;
  localparam logic [3:0]  PROTO_KW_LO  = 4'h3;
  localparam logic [3:0]  PROTO_KW_HI  = 4'h5;
  localparam logic [3:0]  PROTO_CAN_LO = 4'h6;
  localparam logic [3:0]  PROTO_CAN_HI = 4'hc;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] REG_FLAGS  = 8'h00;
  localparam logic [7:0] REG_RESPMS = 8'h04;
  localparam logic [7:0] REG_WAKEMS = 8'h08;
  localparam logic [7:0] REG_KBAUD  = 8'h0c;
  localparam logic [7:0] REG_PROTO  = 8'h10;
  localparam logic [7:0] REG_WMLEN  = 8'h14;
  localparam logic [7:0] REG_WMLO   = 8'h18;
  localparam logic [7:0] REG_WMHI   = 8'h1c;
  localparam logic [7:0] REG_VCAL   = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;
  typedef enum logic [2:0] {
    ST_LINE  = 3'h0,
    ST_EXEC  = 3'h1,
    ST_SEND  = 3'h2,
    ST_WAIT  = 3'h3,
    ST_REPLY = 3'h4
  } obdcp_st_t;
endpackage : obdcp_pkg

// ===== rtl/obdcp_parser.sv
// Purpose: serial command interpreter of a diagnostic bridge
// Assumes: rx bytes and rts synchronous to i_mclk
// Notes:   vehicle engines sit behind the veh port
`timescale 1ns/10ps
module obdcp_parser #(
  parameter logic [31:0] LINE_TMO_CYC = obdcp_pkg::LINE_TMO_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_valid,
  input  wire logic        i_rts,
  input  wire logic        i_tx_ready,
  input  wire logic        i_veh_done,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [7:0]       o_tx_data,
  output logic             o_tx_valid,
  output logic             o_busy,
  output logic [7:0]       o_veh_data,
  output logic             o_veh_valid,
  output logic             o_veh_last,
  output logic             o_veh_abort,
  output logic [31:0]      o_rdata
);
  typedef struct packed {
    obdcp_pkg::obdcp_st_t st;
    logic [31:0][7:0] buf_c;
    logic [5:0]       len;
    logic [5:0]       last_n;
    logic [5:0]       cmd_n;
    logic             ovf;
    logic [31:0]      tmo;
    logic [4:0]       vix;
    logic [47:0]      msg;
    logic [2:0]       msg_n;
    logic [7:0]       tx_d;
    logic             tx_v;
    logic             busy;
    logic [7:0]       veh_d;
    logic             veh_v;
    logic             veh_last;
    logic             veh_abort;
    logic [9:0]       flags;
    logic [7:0]       resp;
    logic [7:0]       wake;
    logic [1:0]       kb;
    logic [3:0]       proto;
    logic [2:0]       wm_n;
    logic [47:0]      wm;
    logic [15:0]      cal;
    logic             cal_def;
    logic [31:0]      rdata;
  } obdcp_state_t;

  obdcp_state_t s_q, s_d;
  logic [31:0]      hx;
  logic [31:0][3:0] nb;
  logic [7:0]       c_up;
  logic             c_drop, pb, kw_ok, can_ok, is_at, at_ok, hex_ok;
  logic [5:0]       nn;
  logic [7:0]       a0, a1, a2, arg8;
  logic [3:0]       fi;
  logic             fsel;

  // ****************************************
  // character classes
  // ****************************************
  always_comb begin
    for (int k = 0; k < obdcp_pkg::BUF_N; k++) begin
      logic [7:0] c;
      c = s_q.buf_c[k];
      hx[k] = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
      nb[k] = (c >= 8'h41) ? 4'(c[3:0] + 4'h9) : c[3:0];
    end
    c_up = (i_rx_data >= 8'h61 && i_rx_data <= 8'h7a) ? i_rx_data - 8'h20 : i_rx_data;
    c_drop = (i_rx_data <= obdcp_pkg::CH_SP && i_rx_data != obdcp_pkg::CH_CR)
             || i_rx_data == obdcp_pkg::CH_DEL;
  end

  // ****************************************
  // internal command decode
  // ****************************************
  always_comb begin
    nn     = s_q.cmd_n - 6'h02;
    a0     = s_q.buf_c[2];
    a1     = s_q.buf_c[3];
    a2     = s_q.buf_c[4];
    arg8   = {nb[4], nb[5]};
    is_at  = s_q.cmd_n >= 6'h02 && s_q.buf_c[0] == "A" && s_q.buf_c[1] == "T";
    pb     = s_q.buf_c[s_q.cmd_n - 6'h01] == "0" || s_q.buf_c[s_q.cmd_n - 6'h01] == "1";
    kw_ok  = s_q.proto == 4'h0 || (s_q.proto >= obdcp_pkg::PROTO_KW_LO
             && s_q.proto <= obdcp_pkg::PROTO_KW_HI);
    can_ok = s_q.proto == 4'h0 || (s_q.proto >= obdcp_pkg::PROTO_CAN_LO
             && s_q.proto <= obdcp_pkg::PROTO_CAN_HI);
    hex_ok = 1'b1;
    for (int k = 0; k < obdcp_pkg::BUF_N; k++) begin
      if (k >= (is_at ? 4 : 0) && k < int'(s_q.cmd_n) && !hx[k]) begin
        hex_ok = 1'b0;
      end
    end
    fsel = 1'b0;
    fi   = 4'h0;
    if (pb && nn == 6'h02) begin
      fsel = 1'b1;
      unique case (a0)
        "E": fi = 4'(obdcp_pkg::FLG_ECHO);
        "H": fi = 4'(obdcp_pkg::FLG_HDR);
        "S": fi = 4'(obdcp_pkg::FLG_SPC);
        "R": fi = 4'(obdcp_pkg::FLG_RSP);
        "D": begin
          fi = 4'(obdcp_pkg::FLG_DLC);
          fsel = can_ok;
        end
        "V": begin
          fi = 4'(obdcp_pkg::FLG_VDLC);
          fsel = can_ok;
        end
        default: fsel = 1'b0;
      endcase
    end else if (pb && nn == 6'h03 && {a0, a1} == "KW") begin
      fi   = 4'(obdcp_pkg::FLG_KW);
      fsel = kw_ok;
    end else if (pb && nn == 6'h04 && can_ok) begin
      fsel = 1'b1;
      unique case ({a0, a1, a2})
        "CAF":   fi = 4'(obdcp_pkg::FLG_CAF);
        "CFC":   fi = 4'(obdcp_pkg::FLG_CFC);
        "CSM":   fi = 4'(obdcp_pkg::FLG_CSM);
        default: fsel = 1'b0;
      endcase
    end
    at_ok = fsel;
    if (hex_ok && nn == 6'h04) begin
      at_ok = at_ok || {a0, a1} == "ST" || ({a0, a1} == "SW" && kw_ok)
              || ({a0, a1} == "SP" && arg8 <= 8'h0c)
              || ({a0, a1} == "IB" && kw_ok
                  && (arg8 == 8'h10 || arg8 == 8'h48 || arg8 == 8'h96));
    end
    if (hex_ok && nn == 6'h03 && {a0, a1} == "SP") begin
      at_ok = 1'b1;
    end
    if (hex_ok && nn == 6'h06 && {a0, a1} == "CV") begin
      at_ok = 1'b1;
    end
    if (hex_ok && nn >= 6'h04 && nn <= 6'h0e && !nn[0] && {a0, a1} == "WM" && kw_ok) begin
      at_ok = 1'b1;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d           = s_q;
    s_d.veh_v     = 1'b0;
    s_d.veh_last  = 1'b0;
    s_d.veh_abort = 1'b0;
    s_d.rdata     = 32'h0000_0000;
    if (s_q.tx_v && i_tx_ready) begin
      s_d.tx_v = 1'b0;
    end
    // ---- register port ----
    if (i_wr && i_addr == obdcp_pkg::REG_FLAGS) begin
      s_d.flags = i_wdata[9:0];
    end
    if (i_rd) begin
      unique case (i_addr)
        obdcp_pkg::REG_FLAGS:  s_d.rdata = {22'h0, s_q.flags};
        obdcp_pkg::REG_RESPMS: s_d.rdata = {22'h0, 10'(s_q.resp * obdcp_pkg::RESP_STEP_MS)};
        obdcp_pkg::REG_WAKEMS: s_d.rdata = {19'h0, 13'(s_q.wake * obdcp_pkg::WAKE_STEP_MS)};
        obdcp_pkg::REG_KBAUD:  s_d.rdata = {15'h0, (s_q.kb == obdcp_pkg::KB_4800)
                                  ? obdcp_pkg::BAUD_4800 : (s_q.kb == obdcp_pkg::KB_9600)
                                  ? obdcp_pkg::BAUD_9600 : obdcp_pkg::BAUD_10400};
        obdcp_pkg::REG_PROTO:  s_d.rdata = {28'h0, s_q.proto};
        obdcp_pkg::REG_WMLEN:  s_d.rdata = {29'h0, s_q.wm_n};
        obdcp_pkg::REG_WMLO:   s_d.rdata = s_q.wm[31:0];
        obdcp_pkg::REG_WMHI:   s_d.rdata = {16'h0, s_q.wm[47:32]};
        obdcp_pkg::REG_VCAL:   s_d.rdata = {15'h0, s_q.cal_def, s_q.cal};
        obdcp_pkg::REG_STATUS: s_d.rdata = {20'h0, s_q.len, s_q.busy, 2'h0, s_q.st};
        default:               s_d.rdata = 32'h0000_0000;
      endcase
    end
    unique case (s_q.st)
      obdcp_pkg::ST_LINE: begin
        if (s_q.len != 6'h00 || s_q.ovf) begin
          s_d.tmo = s_q.tmo + 32'h1;
        end
        if (i_rx_valid && !c_drop) begin
          if (s_q.flags[obdcp_pkg::FLG_ECHO] && (!s_q.tx_v || i_tx_ready)) begin
            s_d.tx_d = c_up;
            s_d.tx_v = 1'b1;
          end
          if (i_rx_data == obdcp_pkg::CH_CR) begin
            s_d.tmo  = 32'h0;
            s_d.len  = 6'h00;
            s_d.busy = 1'b1;
            s_d.st   = obdcp_pkg::ST_EXEC;
            s_d.cmd_n = (s_q.len == 6'h00) ? s_q.last_n : s_q.len;
            if (s_q.len != 6'h00) begin
              s_d.last_n = s_q.len;
            end
            if (s_q.ovf) begin
              s_d.ovf    = 1'b0;
              s_d.last_n = 6'h00;
              s_d.msg    = obdcp_pkg::MSG_ERR;
              s_d.msg_n  = 3'h3;
              s_d.st     = obdcp_pkg::ST_REPLY;
            end
          end else if (s_q.len == 6'(obdcp_pkg::BUF_N)) begin
            s_d.ovf = 1'b1;
          end else begin
            s_d.buf_c[s_q.len[4:0]] = c_up;
            s_d.len = s_q.len + 6'h01;
          end
        end else if (s_q.tmo >= LINE_TMO_CYC - 32'h1) begin
          s_d.tmo    = 32'h0;
          s_d.len    = 6'h00;
          s_d.ovf    = 1'b0;
          s_d.last_n = 6'h00;
          s_d.busy   = 1'b1;
          s_d.msg    = obdcp_pkg::MSG_ERR;
          s_d.msg_n  = 3'h3;
          s_d.st     = obdcp_pkg::ST_REPLY;
        end
      end
      obdcp_pkg::ST_EXEC: begin
        s_d.st    = obdcp_pkg::ST_REPLY;
        s_d.msg   = obdcp_pkg::MSG_ERR;
        s_d.msg_n = 3'h3;
        if (s_q.cmd_n == 6'h00) begin
          s_d.msg   = obdcp_pkg::MSG_PROMPT;
          s_d.msg_n = 3'h1;
        end else if (is_at) begin
          if (at_ok) begin
            s_d.msg   = obdcp_pkg::MSG_OK;
            s_d.msg_n = 3'h4;
            if (fsel) begin
              s_d.flags[fi] = s_q.buf_c[s_q.cmd_n - 6'h01][0];
            end else if ({a0, a1} == "ST") begin
              s_d.resp = arg8;
            end else if ({a0, a1} == "SW") begin
              s_d.wake = arg8;
            end else if ({a0, a1} == "IB") begin
              s_d.kb = (arg8 == 8'h48) ? obdcp_pkg::KB_4800
                     : (arg8 == 8'h96) ? obdcp_pkg::KB_9600 : obdcp_pkg::KB_10400;
            end else if ({a0, a1} == "SP") begin
              s_d.proto = (nn == 6'h03) ? nb[4] : arg8[3:0];
            end else if ({a0, a1} == "CV") begin
              s_d.cal_def = {nb[4], nb[5], nb[6], nb[7]} == 16'h0000;
              if ({nb[4], nb[5], nb[6], nb[7]} != 16'h0000) begin
                s_d.cal = {nb[4], nb[5], nb[6], nb[7]};
              end
            end else begin
              s_d.wm_n = 3'(nn[4:1] - 4'h1);
              for (int b = 0; b < 6; b++) begin
                s_d.wm[b*8 +: 8] = (b < int'(nn[4:1]) - 1) ? {nb[4+2*b], nb[5+2*b]} : 8'h00;
              end
            end
          end
        end else if (hex_ok && !s_q.cmd_n[0]) begin
          s_d.vix = 5'h00;
          s_d.st  = obdcp_pkg::ST_SEND;
        end
      end
      obdcp_pkg::ST_SEND, obdcp_pkg::ST_WAIT: begin
        if (s_q.st == obdcp_pkg::ST_SEND) begin
          s_d.veh_v    = 1'b1;
          s_d.veh_d    = {nb[{s_q.vix[3:0], 1'b0}], nb[{s_q.vix[3:0], 1'b1}]};
          s_d.veh_last = {s_q.vix, 1'b0} + 6'h02 == s_q.cmd_n;
          s_d.vix      = s_q.vix + 5'h01;
          if (s_d.veh_last) begin
            s_d.st = obdcp_pkg::ST_WAIT;
          end
        end
        if (i_rts || i_rx_valid || (s_q.st == obdcp_pkg::ST_WAIT && i_veh_done)) begin
          s_d.veh_abort = i_rts || i_rx_valid;
          s_d.veh_v     = 1'b0;
          s_d.veh_last  = 1'b0;
          s_d.msg       = obdcp_pkg::MSG_PROMPT;
          s_d.msg_n     = 3'h1;
          s_d.st        = obdcp_pkg::ST_REPLY;
        end
      end
      obdcp_pkg::ST_REPLY: begin
        if (s_q.msg_n != 3'h0 && (!s_q.tx_v || i_tx_ready)) begin
          s_d.tx_d  = s_q.msg[7:0];
          s_d.tx_v  = 1'b1;
          s_d.msg   = s_q.msg >> 8;
          s_d.msg_n = s_q.msg_n - 3'h1;
        end
        if (s_q.msg_n == 3'h0) begin
          s_d.busy = 1'b0;
          s_d.st   = obdcp_pkg::ST_LINE;
        end
      end
      default: s_d.st = obdcp_pkg::ST_LINE;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      s_q       <= '0;
      s_q.st    <= obdcp_pkg::ST_REPLY;
      s_q.busy  <= 1'b1;
      s_q.msg   <= obdcp_pkg::MSG_PROMPT;
      s_q.msg_n <= 3'h1;
      s_q.flags <= obdcp_pkg::FLAGS_RST;
      s_q.resp  <= obdcp_pkg::RESP_RST;
      s_q.wake  <= obdcp_pkg::WAKE_RST;
      s_q.kb    <= obdcp_pkg::KB_10400;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tx_data   = s_q.tx_d;
  assign o_tx_valid  = s_q.tx_v;
  assign o_busy      = s_q.busy;
  assign o_veh_data  = s_q.veh_d;
  assign o_veh_valid = s_q.veh_v;
  assign o_veh_last  = s_q.veh_last;
  assign o_veh_abort = s_q.veh_abort;
  assign o_rdata     = s_q.rdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  property p_err_reply;
    s_q.st == obdcp_pkg::ST_EXEC && s_q.cmd_n != 6'h00 && is_at && !at_ok
      |=> s_q.msg[7:0] == 8'h3f && s_q.msg_n == 3'h3;
  endproperty
  a_err_reply: assert property (p_err_reply) else $error("bad command not answered");
  property p_ok_reply;
    s_q.st == obdcp_pkg::ST_EXEC && s_q.cmd_n != 6'h00 && is_at && at_ok
      |=> s_q.msg[15:0] == 16'h4b4f ##[1:8] o_tx_valid && o_tx_data == 8'h4f;
  endproperty
  a_ok_reply: assert property (p_ok_reply) else $error("ok reply missing");
  property p_abort;
    (s_q.st == obdcp_pkg::ST_WAIT && (i_rts || i_rx_valid))
      |=> o_veh_abort && s_q.st == obdcp_pkg::ST_REPLY ##1 !o_veh_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not taken");
  property p_drop;
    s_q.st == obdcp_pkg::ST_LINE && i_rx_valid && i_rx_data == obdcp_pkg::CH_SP
      |=> $stable(s_q.len);
  endproperty
  a_drop: assert property (p_drop) else $error("space stored");
  property p_fold;
    s_q.st == obdcp_pkg::ST_LINE && i_rx_valid && i_rx_data == 8'h61
      && s_q.len < 6'h20 |=> s_q.buf_c[$past(s_q.len[4:0])] == 8'h41;
  endproperty
  a_fold: assert property (p_fold) else $error("case not folded");
  property p_repeat;
    s_q.st == obdcp_pkg::ST_LINE && i_rx_valid && i_rx_data == obdcp_pkg::CH_CR
      && s_q.len == 6'h00 && !s_q.ovf |=> s_q.cmd_n == $past(s_q.last_n);
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat lost");
  property p_defaults;
    !$past(i_resetn) |-> s_q.flags == obdcp_pkg::FLAGS_RST && s_q.kb == obdcp_pkg::KB_10400;
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad reset defaults");
  property p_prompt;
    s_q.st == obdcp_pkg::ST_REPLY && s_q.msg_n == 3'h1 |-> s_q.msg[7:0] == 8'h3e;
  endproperty
  a_prompt: assert property (p_prompt) else $error("reply lacks prompt");
  property p_last;
    o_veh_valid && o_veh_last
      |-> {s_q.vix, 1'b0} == s_q.cmd_n && s_q.st == obdcp_pkg::ST_WAIT;
  endproperty
  a_last: assert property (p_last) else $error("last byte misplaced");
  property p_tmo;
    s_q.st == obdcp_pkg::ST_LINE && !i_rx_valid && s_q.tmo == LINE_TMO_CYC - 32'h1
      |=> s_q.st == obdcp_pkg::ST_REPLY && s_q.msg[7:0] == 8'h3f && s_q.len == 6'h00;
  endproperty
  a_tmo: assert property (p_tmo) else $error("stale line kept");
endmodule : obdcp_parser

// ===== tb/obdcp_host.sv
// Purpose: host model on the serial side of the interpreter
// Assumes: one character per strobe, device never stalls input
// Notes:   slow mode holds off the transmit handshake
`timescale 1ns/10ps
module obdcp_host (
  input  wire logic       i_mclk,
  input  wire logic       i_busy,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_tx_ready
);
  logic [7:0] rxq[$];
  logic       slow = 1'b0;
  logic [1:0] cnt = 2'h0;
  initial begin
    o_rx_data = 8'h00;
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b1;
  end
  always @(posedge i_mclk) begin
    if (i_tx_valid === 1'b1 && o_tx_ready && i_tx_data !== 8'h00) begin
      rxq.push_back(i_tx_data);
    end
    cnt <= cnt + 2'h1;
    o_tx_ready <= !slow || cnt == 2'h3;
  end
  task automatic put(input logic [7:0] c);
    @(posedge i_mclk);
    o_rx_data <= c;
    o_rx_valid <= 1'b1;
    @(posedge i_mclk);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~c;
  endtask : put
  task automatic send_line(input string s);
    int n;
    n = 0;
    while (i_busy !== 1'b0 && n < 5000) begin
      @(posedge i_mclk);
      n++;
    end
    for (int i = 0; i < s.len(); i++) begin
      put(s[i]);
    end
  endtask : send_line
endmodule : obdcp_host

// ===== tb/tb_obd_serial_command_parser.sv
// Purpose: self-checking bench for the serial command interpreter
// Assumes: bench plays the vehicle engine and the register master
// Notes:   line timeout shortened to 200 cycles
`timescale 1ns/10ps
module tb_obd_serial_command_parser;
  logic        i_mclk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_rts = 1'b0;
  logic        i_veh_done = 1'b0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [7:0]  rx_data, tx_data, veh_data;
  logic        rx_valid, tx_valid, tx_ready, busy, veh_valid, veh_last, veh_abort;
  logic [31:0] rdata;
  logic [8:0]  vq[$];
  int          mismatches = 0;
  int          tests_run = 0;
  int          aborts = 0;
  always #5 i_mclk = ~i_mclk;
  obdcp_parser #(.LINE_TMO_CYC(32'd200)) DUT (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_rx_data(rx_data), .i_rx_valid(rx_valid),
    .i_rts(i_rts), .i_tx_ready(tx_ready), .i_veh_done(i_veh_done), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_tx_data(tx_data),
    .o_tx_valid(tx_valid), .o_busy(busy), .o_veh_data(veh_data), .o_veh_valid(veh_valid),
    .o_veh_last(veh_last), .o_veh_abort(veh_abort), .o_rdata(rdata));
  obdcp_host host (
    .i_mclk(i_mclk), .i_busy(busy), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
    .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_tx_ready(tx_ready));
  always @(posedge i_mclk) begin
    if (veh_valid === 1'b1) begin
      vq.push_back({veh_last, veh_data});
    end
    if (veh_abort === 1'b1) begin
      aborts++;
    end
  end
  // ****************************************
  // compare and bus tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic reply(input string exp);
    string got;
    int    n;
    got = "";
    n = 0;
    while (host.rxq.size() < exp.len() && n < 3000) begin
      @(posedge i_mclk);
      n++;
    end
    while (host.rxq.size() > 0) begin
      got = $sformatf("%s%c", got, host.rxq.pop_front());
    end
    tests_run++;
    if (got != exp) begin
      mismatches++;
      $display("CHECK FAILED reply expected %p seen %p", exp, got);
    end
  endtask : reply
  task automatic rck(input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m = 32'hffffffff);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, rdata & m);
  endtask : rck
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic cmd(input string s, input string r);
    host.send_line(s);
    reply(r);
    #1 chk("busy", 32'h0, {31'h0, busy});
  endtask : cmd
  // ****************************************
  // vehicle scenarios
  // ****************************************
  task automatic wait_bytes();
    int n;
    n = 0;
    while (vq.size() < 2 && n < 500) begin
      @(posedge i_mclk);
      n++;
    end
  endtask : wait_bytes
  task automatic veh(input string s, input logic [15:0] exp);
    vq.delete();
    host.send_line(s);
    wait_bytes();
    @(posedge i_mclk);
    i_veh_done <= 1'b1;
    @(posedge i_mclk);
    i_veh_done <= 1'b0;
    chk("veh count", 32'h2, 32'(vq.size()));
    chk("veh byte0", {23'h0, 1'b0, exp[15:8]}, 32'(vq[0]));
    chk("veh byte1", {23'h0, 1'b1, exp[7:0]}, 32'(vq[1]));
    reply(">");
  endtask : veh
  task automatic abort_req(input logic by_char);
    int a0;
    vq.delete();
    host.send_line("0100\r");
    wait_bytes();
    a0 = aborts;
    if (by_char) begin
      host.put(8'h20);
    end else begin
      @(posedge i_mclk);
      i_rts <= 1'b1;
    end
    reply(">");
    chk("abort pulses", 32'h1, 32'(aborts - a0));
    i_rts <= 1'b0;
  endtask : abort_req
  task automatic close_out();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #600000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge i_mclk);
    i_resetn <= 1'b1;
    reply(">");
    rck(8'h00, 32'h3cd);
    rck(8'h04, 32'hc8);
    rck(8'h08, 32'hb68);
    rck(8'h0c, 32'h28a0);
    rck(8'h30, 32'h0);
    cmd("aT e\t0\r", "ATE0\rOK\r>");
    cmd("at s 0\r", "OK\r>");
    rck(8'h00, 32'h3c8);
    cmd("ATST19\r", "OK\r>");
    rck(8'h04, 32'h64);
    cmd("ATSW05\r", "OK\r>");
    rck(8'h08, 32'h64);
    cmd("\r", "OK\r>");
    cmd("ATSW00\r", "OK\r>");
    rck(8'h08, 32'h0);
    host.slow = 1'b1;
    cmd("ATIB48\r", "OK\r>");
    rck(8'h0c, 32'h12c0);
    cmd("atib96\r", "OK\r>");
    rck(8'h0c, 32'h2580);
    cmd("ATIB10\r", "OK\r>");
    rck(8'h0c, 32'h28a0);
    cmd("ATIB11\r", "?\r>");
    host.slow = 1'b0;
    cmd("ATWM112233\r", "OK\r>");
    rck(8'h14, 32'h3);
    rck(8'h18, 32'h332211);
    cmd("ATWM01020304050607\r", "?\r>");
    cmd("ATWM1\r", "?\r>");
    cmd("ATSP6\r", "OK\r>");
    rck(8'h10, 32'h6);
    cmd("ATIB48\r", "?\r>");
    cmd("ATCAF0\r", "OK\r>");
    rck(8'h00, 32'h348);
    cmd("atd1\r", "OK\r>");
    cmd("ATKW0\r", "?\r>");
    rck(8'h00, 32'h358);
    cmd("ATSP00\r", "OK\r>");
    rck(8'h10, 32'h0);
    cmd("ATCV0000\r", "OK\r>");
    rck(8'h20, 32'h10000, 32'h10000);
    cmd("ATQ\r", "?\r>");
    veh("01 0c\r", 16'h010c);
    veh("\r", 16'h010c);
    cmd("010\r", "?\r>");
    cmd("0G\r", "?\r>");
    cmd("\r", "?\r>");
    abort_req(1'b0);
    abort_req(1'b1);
    cmd("AT", "?\r>");
    wr(8'h04, 32'h0);
    rck(8'h04, 32'h64);
    wr(8'h00, 32'h3cd);
    rck(8'h00, 32'h3cd);
    close_out();
  end
endmodule : tb_obd_serial_command_parser
